// >>> verilog/csp_pkg.sv
package csp_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [4:0]  OFS_CTRL      = 5'h00;
  localparam logic [4:0]  OFS_RATE      = 5'h04;
  localparam logic [4:0]  OFS_PITCH     = 5'h08;
  localparam logic [4:0]  OFS_STAT      = 5'h0c;
  localparam logic [4:0]  OFS_FREQ      = 5'h10;
  localparam logic [4:0]  OFS_ERR       = 5'h14;
  localparam logic [4:0]  OFS_EFF       = 5'h18;
  localparam int          CTRL_BASE_BIT = 3;
  localparam int          CTRL_REC_BIT  = 4;
  localparam int          CTRL_LOOP_BIT = 5;
  localparam int          CTRL_O2A_BIT  = 6;
  localparam int          CTRL_AIN_BIT  = 7;
  localparam int          CTRL_MRK_BIT  = 8;
  localparam int          CTRL_PRO_BIT  = 9;
  localparam int          CTRL_CH_LSB   = 10;
  localparam int          PITCH_PRE_LSB = 16;
  localparam logic [11:0] CTRL_RESET    = 12'h000;
  localparam logic [17:0] RATE_RESET    = 18'h0bb80;
  // ---------------------------------------------------------------
  // Rates and divisors
  // ---------------------------------------------------------------
  localparam logic [26:0] CLK_HZ        = 27'h5f5e100;
  localparam logic [19:0] SMALL_DIV     = 20'h003e8;
  localparam logic [19:0] LARGE_DIV     = 20'h00019;
  localparam logic [19:0] LIMIT_DIV     = 20'h00014;
  localparam logic [18:0] BASE_MAX_HZ   = 19'h0bb80;
  localparam logic [18:0] DOUBLE_MAX_HZ = 19'h17700;
  localparam logic [1:0]  DIV_ONE       = 2'h0;
  localparam logic [1:0]  DIV_TWO       = 2'h1;
  localparam logic [1:0]  DIV_FOUR      = 2'h3;
  // ---------------------------------------------------------------
  // Channel sets
  // ---------------------------------------------------------------
  localparam logic [29:0] CH_ALL        = 30'h3fffffff;
  localparam logic [29:0] CH_NO_OPT2    = 30'h003fffff;
  localparam logic [29:0] CH_ANA_AES    = 30'h00003fff;
  localparam logic [29:0] CH_ANA8       = 30'h000000ff;
  typedef enum logic [2:0] {
    SRC_INTERNAL = 3'h0, SRC_WORD = 3'h1, SRC_AES = 3'h2,
    SRC_OPT1     = 3'h3, SRC_OPT2 = 3'h4
  } csp_src_type;
  typedef enum logic [2:0] {
    PRE_NONE     = 3'h0, PRE_UP_SMALL = 3'h1, PRE_DN_SMALL = 3'h2,
    PRE_UP_LARGE = 3'h3, PRE_DN_LARGE = 3'h4
  } csp_preset_type;
  typedef enum logic [1:0] {
    LK_NONE = 2'h0, LK_LOCK = 2'h1, LK_SYNC = 2'h2
  } csp_lock_type;
endpackage : csp_pkg

// >>> verilog/csp_ref_select.sv
`timescale 1ns/1ps
module csp_ref_select (
  // Clock and reset
  input  logic                 ref_clk,
  input  logic                 rst_n,
  input  logic                 ce,
  // Selection and lock
  input  csp_pkg::csp_src_type sel_src,
  input  logic [3:0]           lock_vec,
  // Reference in use
  output csp_pkg::csp_src_type actual_src
);
  // ---------------------------------------------------------------
  // Search
  // ---------------------------------------------------------------
  function automatic logic [2:0] search(input logic [2:0] s, input logic [3:0] lk);
    logic [2:0] res;
    logic [1:0] j;
    logic [2:0] sm1;
    res = 3'h0;
    sm1 = s - 3'h1;
    j   = sm1[1:0];
    for (int k = 0; k < 3; k++) begin
      j = j + 2'h1;
      if (res == 3'h0 && lk[j]) begin
        res = {1'b0, j} + 3'h1;
      end
    end
    return res;
  endfunction : search

  logic [2:0] selv;
  logic [2:0] actv;
  logic [2:0] smi;
  logic [2:0] ami;
  logic [2:0] nxt;
  assign selv = sel_src;
  assign actv = actual_src;
  assign smi  = selv - 3'h1;
  assign ami  = actv - 3'h1;

  always_comb begin
    nxt = 3'h0;
    if (selv == 3'h0 || selv > 3'h4) begin
      nxt = 3'h0;
    end else if (lock_vec[smi[1:0]]) begin
      nxt = selv;
    end else if (actv != 3'h0 && lock_vec[ami[1:0]]) begin
      nxt = actv;
    end else begin
      nxt = search(selv, lock_vec);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      actual_src <= csp_pkg::SRC_INTERNAL;
    end else if (ce) begin
      actual_src <= csp_pkg::csp_src_type'(nxt);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_SEL_INTERNAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && selv == 3'h0 |=> actual_src == csp_pkg::SRC_INTERNAL)
    else $error("internal selection not followed");
  AST_NONE_INTERNAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && lock_vec == 4'h0 |=> actual_src == csp_pkg::SRC_INTERNAL)
    else $error("no lock but external source in use");
  AST_KEEP_SEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && selv != 3'h0 && selv <= 3'h4 && lock_vec[smi[1:0]]
      |=> actual_src == $past(sel_src))
    else $error("locked selected source not used");
endmodule : csp_ref_select

// >>> verilog/csp_clock_ctrl.sv
`timescale 1ns/1ps
module csp_clock_ctrl (
  // Clock, reset, enable
  input  logic        ref_clk,
  input  logic        rst_n,
  input  logic        ce,
  // Avalon-MM slave
  input  logic [4:0]  avs_address,
  input  logic        avs_read,
  input  logic        avs_write,
  input  logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic        avs_waitrequest,
  // Reference receiver pins
  input  logic [3:0]  ref_lock_pin,
  input  logic [3:0]  ref_sync_pin,
  input  logic [15:0] ref_freq_pin,
  input  logic        ext_clk_pin,
  // Host link events
  input  logic        xfer_error,
  input  logic        run_start,
  // Clock outputs
  output logic [2:0]  actual_src,
  output logic        word_clk_out,
  // Routing outputs
  output logic        rec_proc_input_en,
  output logic        rec_proc_output_en,
  output logic        opt2_out_aes,
  output logic        aes_in_from_opt2,
  output logic        marker_fwd_en,
  output logic        aes_cs_professional,
  output logic        opt2_cs_professional,
  output logic [29:0] chan_enable
);
  // ---------------------------------------------------------------
  // Registers and wires
  // ---------------------------------------------------------------
  logic [11:0] ctrl_reg;
  logic [17:0] rate_reg;
  logic [15:0] fine_reg;
  logic [2:0]  pre_reg;
  logic [15:0] err_reg;
  logic [18:0] eff_reg;
  logic [18:0] eff_next;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic        req;
  logic [3:0]  lock_s1;
  logic [3:0]  lock_s2;
  logic [3:0]  sync_s1;
  logic [3:0]  sync_s2;
  logic [15:0] freq_s1;
  logic [15:0] freq_s2;
  logic        ext_s1;
  logic        ext_s2;
  logic        ext_s3;
  logic [7:0]  stat_bits;
  logic [26:0] acc_reg;
  logic [26:0] acc_sum;
  logic        dds_tick;
  logic        half_tick;
  logic [1:0]  div_reg;
  logic [1:0]  div_lim;
  logic        wc_reg;
  logic        master;
  csp_pkg::csp_src_type act_src;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  function automatic logic wr_hit(input logic [4:0] a, input logic [4:0] o,
                                  input logic w, input logic ack);
    return w && ack && (a == o);
  endfunction : wr_hit

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else if (ce) begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address)
      csp_pkg::OFS_CTRL:  rd_mux = {20'h00000, ctrl_reg};
      csp_pkg::OFS_RATE:  rd_mux = {14'h0000, rate_reg};
      csp_pkg::OFS_PITCH: rd_mux = {13'h0000, pre_reg, fine_reg};
      csp_pkg::OFS_STAT:  rd_mux = {21'h000000, stat_bits, actual_src};
      csp_pkg::OFS_FREQ:  rd_mux = {16'h0000, freq_s2};
      csp_pkg::OFS_ERR:   rd_mux = {16'h0000, err_reg};
      csp_pkg::OFS_EFF:   rd_mux = {13'h0000, eff_reg};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
    end else if (ce && avs_read && !ack_reg) begin
      rdata_reg <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_reg <= csp_pkg::CTRL_RESET;
    end else if (ce && wr_hit(avs_address, csp_pkg::OFS_CTRL, avs_write, ack_reg)) begin
      ctrl_reg <= avs_writedata[11:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rate_reg <= csp_pkg::RATE_RESET;
    end else if (ce && wr_hit(avs_address, csp_pkg::OFS_RATE, avs_write, ack_reg)) begin
      rate_reg <= avs_writedata[17:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fine_reg <= 16'h0000;
      pre_reg  <= 3'h0;
    end else if (ce && wr_hit(avs_address, csp_pkg::OFS_PITCH, avs_write, ack_reg)) begin
      fine_reg <= avs_writedata[15:0];
      pre_reg  <= avs_writedata[csp_pkg::PITCH_PRE_LSB +: 3];
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lock_s1 <= 4'h0;
      lock_s2 <= 4'h0;
      sync_s1 <= 4'h0;
      sync_s2 <= 4'h0;
      freq_s1 <= 16'h0000;
      freq_s2 <= 16'h0000;
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
      ext_s3  <= 1'b0;
    end else if (ce) begin
      lock_s1 <= ref_lock_pin;
      lock_s2 <= lock_s1;
      sync_s1 <= ref_sync_pin;
      sync_s2 <= sync_s1;
      freq_s1 <= ref_freq_pin;
      freq_s2 <= freq_s1;
      ext_s1  <= ext_clk_pin;
      ext_s2  <= ext_s1;
      ext_s3  <= ext_s2;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_stat
    assign stat_bits[2*i +: 2] = !lock_s2[i] ? csp_pkg::LK_NONE :
                                 sync_s2[i]  ? csp_pkg::LK_SYNC : csp_pkg::LK_LOCK;
  end

  // ---------------------------------------------------------------
  // Reference selection
  // ---------------------------------------------------------------
  csp_ref_select u_sel (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .sel_src    (csp_pkg::csp_src_type'(ctrl_reg[2:0])),
    .lock_vec   (lock_s2),
    .actual_src (act_src)
  );
  assign actual_src = act_src;
  assign master     = (act_src == csp_pkg::SRC_INTERNAL);

  // ---------------------------------------------------------------
  // Rate offset
  // ---------------------------------------------------------------
  always_comb begin
    logic signed [19:0] nom;
    logic signed [19:0] lim;
    logic signed [19:0] off;
    logic signed [19:0] sum;
    sum = 20'sh00000;
    nom = $signed({2'b00, rate_reg});
    lim = $signed({2'b00, rate_reg} / csp_pkg::LIMIT_DIV);
    off = 20'sh00000;
    case (pre_reg)
      csp_pkg::PRE_UP_SMALL: off = $signed({2'b00, rate_reg} / csp_pkg::SMALL_DIV);
      csp_pkg::PRE_DN_SMALL: off = -$signed({2'b00, rate_reg} / csp_pkg::SMALL_DIV);
      csp_pkg::PRE_UP_LARGE: off = $signed({2'b00, rate_reg} / csp_pkg::LARGE_DIV);
      csp_pkg::PRE_DN_LARGE: off = -$signed({2'b00, rate_reg} / csp_pkg::LARGE_DIV);
      default:               off = {{4{fine_reg[15]}}, fine_reg};
    endcase
    if (off > lim) begin
      off = lim;
    end else if (off < -lim) begin
      off = -lim;
    end
    if (!master) begin
      off = 20'sh00000;
    end
    sum      = nom + off;
    eff_next = sum[18:0];
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eff_reg <= {1'b0, csp_pkg::RATE_RESET};
    end else if (ce) begin
      eff_reg <= eff_next;
    end
  end

  // ---------------------------------------------------------------
  // Synthesizer
  // ---------------------------------------------------------------
  assign acc_sum  = acc_reg + {7'h00, eff_reg, 1'b0};
  assign dds_tick = (acc_sum >= csp_pkg::CLK_HZ);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_reg <= 27'h0000000;
    end else if (ce) begin
      acc_reg <= dds_tick ? acc_sum - csp_pkg::CLK_HZ : acc_sum;
    end
  end

  assign half_tick = master ? dds_tick : (ext_s2 ^ ext_s3);

  // ---------------------------------------------------------------
  // Word clock output
  // ---------------------------------------------------------------
  always_comb begin
    div_lim = csp_pkg::DIV_ONE;
    if (ctrl_reg[csp_pkg::CTRL_BASE_BIT]) begin
      if (eff_reg > csp_pkg::DOUBLE_MAX_HZ) begin
        div_lim = csp_pkg::DIV_FOUR;
      end else if (eff_reg > csp_pkg::BASE_MAX_HZ) begin
        div_lim = csp_pkg::DIV_TWO;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_reg <= 2'h0;
      wc_reg  <= 1'b0;
    end else if (ce && half_tick) begin
      if (div_reg >= div_lim) begin
        div_reg <= 2'h0;
        wc_reg  <= ~wc_reg;
      end else begin
        div_reg <= div_reg + 2'h1;
      end
    end
  end
  assign word_clk_out = wc_reg;

  // ---------------------------------------------------------------
  // Error counter
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      err_reg <= 16'h0000;
    end else if (ce) begin
      if (run_start) begin
        err_reg <= xfer_error ? 16'h0001 : 16'h0000;
      end else if (xfer_error && err_reg != 16'hffff) begin
        err_reg <= err_reg + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Routing outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rec_proc_input_en    <= 1'b0;
      rec_proc_output_en   <= 1'b0;
      opt2_out_aes         <= 1'b0;
      aes_in_from_opt2     <= 1'b0;
      marker_fwd_en        <= 1'b0;
      aes_cs_professional  <= 1'b0;
      opt2_cs_professional <= 1'b0;
      chan_enable          <= csp_pkg::CH_ALL;
    end else if (ce) begin
      rec_proc_input_en  <= ctrl_reg[csp_pkg::CTRL_REC_BIT] &
                            ~ctrl_reg[csp_pkg::CTRL_LOOP_BIT];
      rec_proc_output_en <= ctrl_reg[csp_pkg::CTRL_REC_BIT] &
                            ctrl_reg[csp_pkg::CTRL_LOOP_BIT];
      opt2_out_aes       <= ctrl_reg[csp_pkg::CTRL_O2A_BIT];
      aes_in_from_opt2   <= ctrl_reg[csp_pkg::CTRL_AIN_BIT];
      marker_fwd_en      <= ctrl_reg[csp_pkg::CTRL_MRK_BIT];
      aes_cs_professional  <= ctrl_reg[csp_pkg::CTRL_PRO_BIT];
      opt2_cs_professional <= ctrl_reg[csp_pkg::CTRL_PRO_BIT] &
                              ctrl_reg[csp_pkg::CTRL_O2A_BIT];
      case (ctrl_reg[csp_pkg::CTRL_CH_LSB +: 2])
        2'h1:    chan_enable <= csp_pkg::CH_NO_OPT2;
        2'h2:    chan_enable <= csp_pkg::CH_ANA_AES;
        2'h3:    chan_enable <= csp_pkg::CH_ANA8;
        default: chan_enable <= csp_pkg::CH_ALL;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_bus_new;
    ce && req && !ack_reg;
  endsequence
  sequence s_wc_normal;
    ce && half_tick && !ctrl_reg[csp_pkg::CTRL_BASE_BIT];
  endsequence
  sequence s_wc_hold;
    ce && half_tick && div_lim == csp_pkg::DIV_FOUR && div_reg != 2'h3;
  endsequence

  AST_BUS_ONE_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_bus_new |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  AST_WC_NORMAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_wc_normal |=> word_clk_out != $past(word_clk_out))
    else $error("word clock missed a half period");
  AST_WC_BASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_wc_hold |=> $stable(word_clk_out))
    else $error("base-rate word clock not divided");
  AST_PITCH_MASTER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && !master |=> eff_reg == {1'b0, $past(rate_reg)})
    else $error("offset applied while not master");
  AST_PITCH_LIMIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce |=> eff_reg <= {1'b0, $past(rate_reg)} + {1'b0, $past(rate_reg)} / 19'h00014)
    else $error("rate above offset window");
  AST_ERR_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && run_start && !xfer_error |=> err_reg == 16'h0000)
    else $error("error count not cleared");
  AST_ERR_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && !run_start && xfer_error && err_reg != 16'hffff
      |=> err_reg == $past(err_reg) + 16'h0001)
    else $error("error not counted");
  AST_REC_ROUTE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(rec_proc_input_en && rec_proc_output_en))
    else $error("both record chains active");
endmodule : csp_clock_ctrl

// >>> testbench/csp_source_model.sv
`timescale 1ns/1ps
module csp_source_model #(
  parameter int HALF = 40
) (
  // Clock and wanted state
  input  wire logic        ref_clk,
  input  wire logic [3:0]  lock_want,
  input  wire logic [3:0]  sync_want,
  input  wire logic [15:0] freq_want,
  input  wire logic        clk_run,
  // Receiver pins
  output logic [3:0]       ref_lock_pin,
  output logic [3:0]       ref_sync_pin,
  output logic [15:0]      ref_freq_pin,
  output logic             ext_clk_pin
);
  // ---------------------------------------
  // Receivers and recovered clock
  // ---------------------------------------
  int cnt;
  initial begin
    cnt = 0;
    ext_clk_pin = 1'b0;
    ref_lock_pin = 4'h0;
    ref_sync_pin = 4'h0;
    ref_freq_pin = 16'h0000;
  end
  // Sync only with lock
  always @(posedge ref_clk) begin
    ref_lock_pin <= lock_want;
    ref_sync_pin <= sync_want & lock_want;
    ref_freq_pin <= freq_want;
  end
  // Clock stands still outside a run
  always @(posedge ref_clk) begin
    if (!clk_run) begin
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ext_clk_pin <= ~ext_clk_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : csp_source_model

// >>> testbench/test_clock_source_select_pitch.sv
`timescale 1ns/1ps
module test_clock_source_select_pitch;
  // ---------------------------------------
  // Signals and instances
  // ---------------------------------------
  logic        ref_clk, rst_n, ce, avs_read, avs_write, xfer_error, run_start, clk_run;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, c, r, e, seed;
  logic        avs_waitrequest, word_clk_out, ext_clk_pin;
  logic        rpi, rpo, o2a, ain, mfw, acp, ocp;
  logic [3:0]  lk, sy, ref_lock_pin, ref_sync_pin;
  logic [15:0] fq, ref_freq_pin;
  logic [2:0]  actual_src, cur;
  logic [29:0] chan_enable;
  logic [29:0] chs [4];
  int          num_errors, checks_done, n, f, t;
  csp_clock_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ref_lock_pin(ref_lock_pin), .ref_sync_pin(ref_sync_pin), .ref_freq_pin(ref_freq_pin),
    .ext_clk_pin(ext_clk_pin), .xfer_error(xfer_error), .run_start(run_start),
    .actual_src(actual_src), .word_clk_out(word_clk_out), .rec_proc_input_en(rpi),
    .rec_proc_output_en(rpo), .opt2_out_aes(o2a), .aes_in_from_opt2(ain),
    .marker_fwd_en(mfw), .aes_cs_professional(acp), .opt2_cs_professional(ocp),
    .chan_enable(chan_enable));
  csp_source_model src (.ref_clk(ref_clk), .lock_want(lk), .sync_want(sy), .freq_want(fq),
    .clk_run(clk_run), .ref_lock_pin(ref_lock_pin), .ref_sync_pin(ref_sync_pin),
    .ref_freq_pin(ref_freq_pin), .ext_clk_pin(ext_clk_pin));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ---------------------------------------
  // Helpers
  // ---------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [2:0] exp_src(logic [2:0] s, logic [3:0] l, logic [2:0] k);
    if (s == 3'h0 || s > 3'h4) return 3'h0;
    if (l[s-1]) return s;
    if (k != 3'h0 && l[k-1]) return k;
    for (int i = 1; i < 4; i++) if (l[(s - 1 + i) % 4]) return 3'((s - 1 + i) % 4 + 1);
    return 3'h0;
  endfunction : exp_src
  function automatic logic [31:0] exp_eff(int m, int p, int o);
    int v;
    v = p == 1 ? m / 1000 : p == 2 ? -(m / 1000) : p == 3 ? m / 25 : p == 4 ? -(m / 25) : o;
    v = v > m / 20 ? m / 20 : v < -(m / 20) ? -(m / 20) : v;
    return 32'(m + v);
  endfunction : exp_eff
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic near(input int g, input int x);
    chk((g - x <= 2 && x - g <= 2) ? x : g, x);
  endtask : near
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      num_errors++;
      close_out();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic count(input int cyc);
    logic p;
    t = 0;
    p = word_clk_out;
    repeat (cyc) begin
      @(posedge ref_clk);
      if (word_clk_out !== p) t++;
      p = word_clk_out;
    end
  endtask : count
  task automatic pulse(input logic er, input logic rs);
    @(posedge ref_clk);
    xfer_error <= er;
    run_start <= rs;
    @(posedge ref_clk);
    xfer_error <= 1'b0;
    run_start <= 1'b0;
  endtask : pulse
  // ---------------------------------------
  // Main sequence
  // ---------------------------------------
  initial begin
    chs = '{csp_pkg::CH_ALL, csp_pkg::CH_NO_OPT2, csp_pkg::CH_ANA_AES, csp_pkg::CH_ANA8};
    {seed, rst_n, ce, avs_read, avs_write, avs_address, avs_writedata} = {32'h7, 4'h4, 37'h0};
    {xfer_error, run_start, clk_run, lk, sy, fq, cur, num_errors, checks_done} = '0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, csp_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, csp_pkg::OFS_EFF, 32'h0);
    chk(rd, 32'h0bb80);
    chk(chan_enable, csp_pkg::CH_ALL);
    bus(1'b0, 5'h1c, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 24; i++) begin
      c = xs() & 32'hfff;
      bus(1'b1, csp_pkg::OFS_CTRL, c);
      repeat (6) @(posedge ref_clk);
      cur = exp_src(c[2:0], lk, cur);
      chk(actual_src, cur);
      chk({rpi, rpo, o2a, ain}, {c[4] & ~c[5], c[4] & c[5], c[6], c[7]});
      chk({mfw, acp, ocp}, {c[8], c[9], c[9] & c[6]});
      chk(chan_enable, chs[c[11:10]]);
      r = xs();
      {fq, sy, lk} <= r[23:0];
      repeat (8) @(posedge ref_clk);
      cur = exp_src(c[2:0], lk, cur);
      e = 32'(cur);
      for (int k = 0; k < 4; k++) e[3+2*k+:2] = lk[k] ? (sy[k] ? 2'h2 : 2'h1) : 2'h0;
      bus(1'b1, csp_pkg::OFS_STAT, 32'hffffffff);
      bus(1'b0, csp_pkg::OFS_STAT, 32'h0);
      chk(rd, e);
      bus(1'b0, csp_pkg::OFS_FREQ, 32'h0);
      chk(rd, 32'(fq));
    end
    lk <= 4'h0;
    bus(1'b1, csp_pkg::OFS_CTRL, 32'h0);
    for (int p = 0; p < 8; p++) begin
      n = 32000 + int'(xs() % 16001);
      f = int'(xs() % 121) * 50 - 3000 + int'(xs() % 3) - 1;
      bus(1'b1, csp_pkg::OFS_RATE, 32'(n));
      bus(1'b1, csp_pkg::OFS_PITCH, {13'h0, 3'(p), 16'(f)});
      repeat (2) @(posedge ref_clk);
      bus(1'b0, csp_pkg::OFS_EFF, 32'h0);
      chk(rd, exp_eff(n, p, f));
    end
    lk <= 4'h1;
    bus(1'b1, csp_pkg::OFS_CTRL, 32'h1);
    repeat (8) @(posedge ref_clk);
    bus(1'b0, csp_pkg::OFS_EFF, 32'h0);
    chk(rd, 32'(n));
    bus(1'b1, csp_pkg::OFS_PITCH, 32'h0);
    bus(1'b1, csp_pkg::OFS_RATE, 32'h0bb80);
    clk_run <= 1'b1;
    count(4000);
    near(t, 100);
    clk_run <= 1'b0;
    lk <= 4'h0;
    for (int k = 0; k < 4; k++) begin
      n = k == 0 ? 48000 : k == 3 ? 192000 : 96000;
      bus(1'b1, csp_pkg::OFS_RATE, 32'(n));
      bus(1'b1, csp_pkg::OFS_CTRL, (k > 1) ? 32'h8 : 32'h0);
      count(10000);
      near(t, n / 5000 / ((k > 1) ? n / 48000 : 1));
    end
    n = int'(xs() % 20) + 3;
    repeat (n) pulse(1'b1, 1'b0);
    bus(1'b0, csp_pkg::OFS_ERR, 32'h0);
    chk(rd, 32'(n));
    pulse(1'b0, 1'b1);
    bus(1'b0, csp_pkg::OFS_ERR, 32'h0);
    chk(rd, 32'h0);
    pulse(1'b1, 1'b1);
    bus(1'b0, csp_pkg::OFS_ERR, 32'h0);
    chk(rd, 32'h1);
    // Clock enable low freezes the count
    ce <= 1'b0;
    pulse(1'b1, 1'b0);
    ce <= 1'b1;
    bus(1'b0, csp_pkg::OFS_ERR, 32'h0);
    chk(rd, 32'h1);
    close_out();
  end
endmodule : test_clock_source_select_pitch
